// File: shared/pixel_seq_defs.svh
// constants for the ccd pixel sequencer
`ifndef PIXEL_SEQ_DEFS_SVH
`define PIXEL_SEQ_DEFS_SVH
`define ADR_LINE_PATTERN  3'h7
`define AREA_EN_BIT       0
`define CH_SEL_LO         6
`define CH_SEL_HI         7
`define LAT_OUT           6
`define LAT_BUS_TRI       9
`define LAT_BUS_MONO      7
`define CH_RED            2'h0
`define CH_GREEN          2'h1
`define CH_BLUE           2'h2
`endif

// File: shared/pixel_seq_pkg.sv
// types for the ccd pixel sequencer
package pixel_seq_pkg;
  typedef enum logic [2:0] {
    MODE_TRI_CDS  = 3'b000,
    MODE_TRI_SHA  = 3'b001,
    MODE_MONO_CDS = 3'b010,
    MODE_MONO_SHA = 3'b011,
    MODE_AREA     = 3'b100
  } op_mode_t;
endpackage

// File: rtl/skid_buffer.sv
// two-entry valid/ready buffer on the output data path
`timescale 1ns/10ps
`default_nettype none
module skid_buffer #(
  parameter int W = 12
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_q [2];
  logic         wr_q;
  logic         rd_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// File: rtl/ccd_pixel_sequencer.sv
// ccd front-end sequencing and post-conversion pixel pipeline
// What this block does
// - sample-and-hold modes sample on reset strobe falling edge; video strobe held low.
// - three-channel modes step multiplexer red, green, blue, repeating.
// - sample gets odd/even offset, minus offset bus, times 1 + gain bus/2^GW.
// - three-channel: output 6 cycles after sample, bus values 9 cycles.
// - single-channel and area modes: output 6 cycles, bus values 7 cycles.
// - marker low resets: red channel selected in three-channel modes, even pixel expected next.
// - three-channel: first set even after marker rises, then sets alternate.
// - single-channel: config bits 6 and 7 pick the fixed input.
// - single-channel: odd/even alternates every pixel, starting even.
// - writing one to bit 0 of register 7 enables area mode.
// - area mode: all pixels even, using even offset registers.
// - area mode lines alternate green/red type and blue/green type.
// - rewriting area enable during marker low restarts green-first line.
// - area mode red and blue go through blue channel settings.
// - area mode multiplexer cycles between green and blue inputs.
// - odd/even offsets are two's complement, -128 to +127.
// - offset bus latched on rising clock edge, subtracted unsigned.
// - per-colour register writes go to colour named by colour pointer.
`timescale 1ns/10ps
`default_nettype none
`include "pixel_seq_defs.svh"
module ccd_pixel_sequencer #(
  parameter int DW  = 12,
  parameter int OW  = 10,
  parameter int GW  = 12
) (
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  input  wire pixel_seq_pkg::op_mode_t  op_mode,
  input  wire logic [7:0]               config_reg,
  input  wire logic [1:0]               color_ptr,
  input  wire logic                     reg_wr,
  input  wire logic [2:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     odd_ofs_wr,
  input  wire logic                     even_ofs_wr,
  input  wire logic                     reset_level_strobe,
  input  wire logic                     video_level_strobe,
  input  wire logic                     line_start_marker,
  input  wire logic [DW-1:0]            adc_code,
  input  wire logic [OW-1:0]            offset_bus,
  input  wire logic [GW-1:0]            gain_bus,
  input  wire logic                     dout_ready,
  output logic                          sample_take,
  output logic [1:0]                    mux_sel,
  output logic                          clamp_allowed,
  output logic [7:0]                    line_pattern_mode_control_q,
  output logic                          dout_valid,
  output logic [DW-1:0]                 dout,
  output logic                          in_stall
);
  // ==========================================================
  // state
  // ==========================================================
  localparam int MAXL = `LAT_BUS_TRI;
  logic [2:0]  strobe_sync_q;
  logic [1:0]  marker_sync_q;
  logic        even_q;
  logic [1:0]  color_q;
  logic        area_line_q;
  logic        area_restart_q;
  logic        marker_prev_q;
  logic signed [7:0] odd_ofs_q  [3];
  logic signed [7:0] even_ofs_q [3];
  logic [DW-1:0] code_pipe_q [MAXL];
  logic [OW-1:0] ofs_pipe_q  [MAXL];
  logic [GW-1:0] gain_pipe_q [MAXL];
  logic [1:0]    col_pipe_q  [MAXL];
  logic          par_pipe_q  [MAXL];
  logic [MAXL-1:0] vld_pipe_q;
  logic [DW-1:0] stage_q;
  logic          stage_vld_q;
  logic          sha_mode;
  logic          tri_mode;
  logic          area_mode;
  logic          strobe_fall;
  logic          buf_ready;
  logic          buf_valid;
  logic [DW-1:0] buf_data;
  logic          new_pixel;
  logic          par_q;
  logic          buf_push;
  logic          buf_pop;

  assign sha_mode  = (op_mode == pixel_seq_pkg::MODE_TRI_SHA) ||
                     (op_mode == pixel_seq_pkg::MODE_MONO_SHA);
  assign tri_mode  = (op_mode == pixel_seq_pkg::MODE_TRI_CDS) ||
                     (op_mode == pixel_seq_pkg::MODE_TRI_SHA);
  assign area_mode = line_pattern_mode_control_q[`AREA_EN_BIT];

  // correction arithmetic: odd/even add, bus subtract, gain multiply
  function automatic logic [DW-1:0] correct(input logic [DW-1:0] code,
                                            input logic signed [7:0] oe,
                                            input logic [OW-1:0] ofs,
                                            input logic [GW-1:0] gn);
    logic signed [DW+2:0] s;
    logic [DW+GW+1:0]     p;
    s = $signed({3'b000, code}) + oe;
    s = s - $signed({{(DW+3-OW){1'b0}}, ofs});
    if (s < 0) begin
      s = '0;
    end
    // gain: 1 + g/2^GW, done as code + code*g >> GW
    p = {{(GW+1){1'b0}}, s[DW:0]} * {{(DW+2){1'b0}}, gn};
    p = (p >> GW) + {{(GW+1){1'b0}}, s[DW:0]};
    if (p > {{(GW+2){1'b0}}, {DW{1'b1}}}) begin
      correct = {DW{1'b1}};
    end else begin
      correct = p[DW-1:0];
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strobe_sync_q <= 3'h0;
      marker_sync_q <= 2'h0;
    end else begin
      strobe_sync_q <= {strobe_sync_q[1:0], reset_level_strobe};
      marker_sync_q <= {marker_sync_q[0], line_start_marker};
    end
  end

  // sha modes: reset strobe alone clocks sampling on its falling edge
  assign strobe_fall = strobe_sync_q[2] && !strobe_sync_q[1];
  // cds modes sample once per converter clock, video strobe unused here
  assign new_pixel   = (sha_mode ? strobe_fall : 1'b1) && !in_stall;

  // ==========================================================
  // configuration registers
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      line_pattern_mode_control_q <= 8'h00;
      area_restart_q              <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `ADR_LINE_PATTERN) begin
        line_pattern_mode_control_q <= reg_wdata;
        // rewrite during marker low restarts the green-first line type
        area_restart_q <= reg_wdata[`AREA_EN_BIT] && !marker_sync_q[1];
      end else if (marker_sync_q[1]) begin
        area_restart_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        odd_ofs_q[i]  <= 8'sh00;
        even_ofs_q[i] <= 8'sh00;
      end
    end else begin
      if (odd_ofs_wr && color_ptr != 2'h3) begin
        odd_ofs_q[color_ptr] <= $signed(reg_wdata);
      end
      if (even_ofs_wr && color_ptr != 2'h3) begin
        even_ofs_q[color_ptr] <= $signed(reg_wdata);
      end
    end
  end

  // clamp is only meaningful in cds modes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      clamp_allowed <= 1'b0;
    end else begin
      clamp_allowed <= !sha_mode;
    end
  end

  // ==========================================================
  // multiplexer and odd/even sequencing
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      color_q       <= `CH_RED;
      even_q        <= 1'b1;
      area_line_q   <= 1'b0;
      marker_prev_q <= 1'b0;
    end else begin
      marker_prev_q <= marker_sync_q[1];
      if (!marker_sync_q[1]) begin
        even_q <= 1'b1;
        if (area_mode) begin
          // line type toggles at each marker fall, forced by restart
          if (area_restart_q) begin
            area_line_q <= 1'b0;
          end else if (marker_prev_q) begin
            area_line_q <= ~area_line_q;
          end
          // settles one clock after the fall; marker must stay low two clocks
          color_q <= area_line_q ? `CH_BLUE : `CH_GREEN;
        end else if (tri_mode) begin
          color_q <= `CH_RED;
        end else begin
          color_q <= config_reg[`CH_SEL_HI:`CH_SEL_LO];
        end
      end else if (new_pixel) begin
        if (area_mode) begin
          even_q <= 1'b1;
          // area pixels: green/blue inputs; red shares blue path
          if (color_q == `CH_GREEN) begin
            color_q <= `CH_BLUE;
          end else begin
            color_q <= `CH_GREEN;
          end
        end else if (tri_mode) begin
          case (color_q)
            `CH_RED:   color_q <= `CH_GREEN;
            `CH_GREEN: color_q <= `CH_BLUE;
            default: begin
              color_q <= `CH_RED;
              even_q  <= ~even_q;
            end
          endcase
        end else begin
          color_q <= config_reg[`CH_SEL_HI:`CH_SEL_LO];
          even_q  <= ~even_q;
        end
      end
    end
  end

  // held under stall so a pending pixel keeps its colour and parity
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mux_sel     <= `CH_RED;
      sample_take <= 1'b0;
      par_q       <= 1'b1;
    end else if (!in_stall) begin
      sample_take <= new_pixel && marker_sync_q[1];
      par_q       <= even_q || area_mode;
      mux_sel     <= color_q;
    end
  end

  // ==========================================================
  // latency pipeline
  // ==========================================================
  // samples enter at depth 0; bus values are taken so they meet the
  // sample at the multiplier after the mode's bus latency
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vld_pipe_q <= '0;
    end else if (!in_stall) begin
      vld_pipe_q <= {vld_pipe_q[MAXL-2:0], sample_take};
    end
  end

  generate
    for (genvar k = 0; k < MAXL; k++) begin : g_pipe
      always_ff @(posedge ref_clk) begin
        if (!in_stall) begin
          if (k == 0) begin
            code_pipe_q[k] <= adc_code;
            col_pipe_q[k]  <= mux_sel;
            par_pipe_q[k]  <= par_q;
            ofs_pipe_q[k]  <= offset_bus;
            gain_pipe_q[k] <= gain_bus;
          end else begin
            code_pipe_q[k] <= code_pipe_q[k-1];
            col_pipe_q[k]  <= col_pipe_q[k-1];
            par_pipe_q[k]  <= par_pipe_q[k-1];
            ofs_pipe_q[k]  <= ofs_pipe_q[k-1];
            gain_pipe_q[k] <= gain_pipe_q[k-1];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // correction stage
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage_vld_q <= 1'b0;
      stage_q     <= '0;
    end else if (!in_stall) begin
      stage_vld_q <= vld_pipe_q[`LAT_OUT-2];
      if (tri_mode && !area_mode) begin
        stage_q <= correct(code_pipe_q[`LAT_OUT-2],
                           par_pipe_q[`LAT_OUT-2]
                             ? even_ofs_q[col_pipe_q[`LAT_OUT-2]]
                             : odd_ofs_q[col_pipe_q[`LAT_OUT-2]],
                           ofs_pipe_q[`LAT_BUS_TRI-2],
                           gain_pipe_q[`LAT_BUS_TRI-2]);
      end else begin
        stage_q <= correct(code_pipe_q[`LAT_OUT-2],
                           par_pipe_q[`LAT_OUT-2]
                             ? even_ofs_q[col_pipe_q[`LAT_OUT-2]]
                             : odd_ofs_q[col_pipe_q[`LAT_OUT-2]],
                           ofs_pipe_q[`LAT_BUS_MONO-2],
                           gain_pipe_q[`LAT_BUS_MONO-2]);
      end
    end
  end

  // ==========================================================
  // output buffer; a receiver stall freezes the pipeline
  // ==========================================================
  assign buf_push = stage_vld_q && !in_stall && buf_ready;
  assign buf_pop  = buf_valid && (dout_ready || !dout_valid);

  skid_buffer #(
    .W (DW)
  ) u_buf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (stage_vld_q && !in_stall),
    .in_ready  (buf_ready),
    .in_data   (stage_q),
    .out_valid (buf_valid),
    .out_ready (dout_ready || !dout_valid),
    .out_data  (buf_data)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_stall   <= 1'b0;
      dout_valid <= 1'b0;
      dout       <= '0;
    end else begin
      // full as of this edge, so no word is ever offered to a full buffer
      in_stall <= (!buf_ready && !buf_pop) ||
                  (buf_ready && buf_valid && buf_push && !buf_pop);
      if (dout_ready || !dout_valid) begin
        dout_valid <= buf_valid;
        dout       <= buf_data;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/ccd_sensor_model.sv
// sensor and timing generator model facing the pixel sequencer
`timescale 1ns/10ps
`default_nettype none
module ccd_sensor_model #(
  parameter int DW = 12
) (
  input  wire logic          ref_clk,
  input  wire logic          line_on,
  input  wire logic          slow,
  input  wire logic [DW-1:0] level,
  output logic               reset_level_strobe,
  output logic               video_level_strobe,
  output logic               line_start_marker,
  output logic [DW-1:0]      adc_code
);
  // ==========
  // strobe timing
  logic [2:0] ph_q = 3'h0;
  // strobe stands still outside lines; slow halves the pixel rate
  always @(negedge ref_clk) begin
    ph_q <= ph_q + 3'h1;
    reset_level_strobe <= line_on && (slow ? ph_q[2] : ph_q[1]);
    video_level_strobe <= 1'b0;
    line_start_marker <= line_on;
    adc_code <= level;
  end
endmodule
`default_nettype wire

// File: bench/ccd_pixel_sequencer_properties.sv
// port assertions for the pixel sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pixel_seq_defs.svh"
module ccd_pixel_sequencer_properties #(
  parameter int DW = 12
) (
  input wire logic                    ref_clk,
  input wire logic                    sys_rst,
  input wire pixel_seq_pkg::op_mode_t op_mode,
  input wire logic [7:0]              config_reg,
  input wire logic                    reg_wr,
  input wire logic [2:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    line_start_marker,
  input wire logic                    dout_ready,
  input wire logic                    sample_take,
  input wire logic [1:0]              mux_sel,
  input wire logic                    clamp_allowed,
  input wire logic [7:0]              line_pattern_mode_control_q,
  input wire logic                    in_stall,
  input wire logic                    dout_valid,
  input wire logic [DW-1:0]           dout
);
  // ==========
  // helpers
  logic tri_m;
  logic mono_m;
  logic area_m;
  assign tri_m = !op_mode[1] && !op_mode[2];
  assign mono_m = op_mode[1] && !op_mode[2];
  assign area_m = line_pattern_mode_control_q[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // properties
  chk_reg_write: assert property (
    reg_wr && reg_addr == `ADR_LINE_PATTERN |=> line_pattern_mode_control_q == $past(reg_wdata))
    else $error("mode register write lost");
  chk_reg_hold: assert property (
    !(reg_wr && reg_addr == `ADR_LINE_PATTERN) |=> $stable(line_pattern_mode_control_q))
    else $error("mode register changed without write");
  chk_clamp_sha: assert property ($past(op_mode[0]) && op_mode[0] |-> !clamp_allowed)
    else $error("clamp allowed in sample-and-hold mode");
  chk_mono_fixed: assert property (
    (mono_m && !area_m && $stable(config_reg) && $stable(op_mode)) [*3]
    |-> mux_sel == config_reg[7:6])
    else $error("single-channel input not fixed");
  chk_marker_red: assert property ((tri_m && !area_m && !line_start_marker) [*5]
    |-> mux_sel == `CH_RED)
    else $error("marker low did not select red");
  chk_tri_order: assert property (
    (tri_m && !area_m && line_start_marker) [*5] ##0 $changed(mux_sel)
    |-> mux_sel == ($past(mux_sel) == 2'h2 ? 2'h0 : $past(mux_sel) + 2'h1))
    else $error("channel order broken");
  chk_area_pair: assert property ((area_m && line_start_marker) [*8]
    |-> mux_sel inside {`CH_GREEN, `CH_BLUE})
    else $error("area mode left green and blue");
  chk_dout_hold: assert property (
    dout_valid && !dout_ready |=> dout_valid && $stable(dout))
    else $error("output word dropped under stall");
  chk_out_latency: assert property (
    disable iff (sys_rst || !dout_ready || !line_start_marker)
    sample_take && !in_stall |-> ##[6:10] dout_valid)
    else $error("output latency out of range");
endmodule
bind ccd_pixel_sequencer ccd_pixel_sequencer_properties #(.DW(DW)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .op_mode(op_mode), .config_reg(config_reg),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .line_start_marker(line_start_marker), .dout_ready(dout_ready),
  .sample_take(sample_take), .mux_sel(mux_sel), .clamp_allowed(clamp_allowed),
  .line_pattern_mode_control_q(line_pattern_mode_control_q), .in_stall(in_stall),
  .dout_valid(dout_valid), .dout(dout));
`default_nettype wire

// File: bench/ccd_pixel_sequencer_test.sv
// self-checking bench for the pixel sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", nm, e, a); end end
module ccd_pixel_sequencer_test;
  logic                     ref_clk, sys_rst, reg_wr, odd_ofs_wr, even_ofs_wr;
  logic                     reset_level_strobe, video_level_strobe, line_start_marker;
  logic                     dout_ready, sample_take, clamp_allowed, dout_valid, in_stall;
  logic                     line_on, slow;
  pixel_seq_pkg::op_mode_t  op_mode;
  logic [7:0]               config_reg, reg_wdata, line_pattern_mode_control_q;
  logic [1:0]               color_ptr, mux_sel;
  logic [2:0]               reg_addr;
  logic [11:0]              adc_code, gain_bus, dout, level;
  logic [9:0]               offset_bus;
  int                       fail_count, checks;
  ccd_pixel_sequencer dut (
    .ref_clk                     (ref_clk),
    .sys_rst                     (sys_rst),
    .op_mode                     (op_mode),
    .config_reg                  (config_reg),
    .color_ptr                   (color_ptr),
    .reg_wr                      (reg_wr),
    .reg_addr                    (reg_addr),
    .reg_wdata                   (reg_wdata),
    .odd_ofs_wr                  (odd_ofs_wr),
    .even_ofs_wr                 (even_ofs_wr),
    .reset_level_strobe          (reset_level_strobe),
    .video_level_strobe          (video_level_strobe),
    .line_start_marker           (line_start_marker),
    .adc_code                    (adc_code),
    .offset_bus                  (offset_bus),
    .gain_bus                    (gain_bus),
    .dout_ready                  (dout_ready),
    .sample_take                 (sample_take),
    .mux_sel                     (mux_sel),
    .clamp_allowed               (clamp_allowed),
    .line_pattern_mode_control_q (line_pattern_mode_control_q),
    .dout_valid                  (dout_valid),
    .dout                        (dout),
    .in_stall                    (in_stall)
  );
  ccd_sensor_model partner (
    .ref_clk            (ref_clk),
    .line_on            (line_on),
    .slow               (slow),
    .level              (level),
    .reset_level_strobe (reset_level_strobe),
    .video_level_strobe (video_level_strobe),
    .line_start_marker  (line_start_marker),
    .adc_code           (adc_code)
  );
  // ==========
  // shared tasks
  task automatic print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic [1:0] k);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    color_ptr = a[1:0];
    reg_wr = k == 2'h0;
    odd_ofs_wr = k == 2'h1;
    even_ofs_wr = k == 2'h2;
    @(negedge ref_clk);
    {reg_wr, odd_ofs_wr, even_ofs_wr} = 3'h0;
  endtask
  // words alternate e0, e1 from the start of the line
  task automatic run_line(input logic [11:0] c, input logic [9:0] o,
                          input logic [11:0] g, e0, e1, input logic stall);
    logic [11:0] q[$];
    int n;
    level = c;
    offset_bus = o;
    gain_bus = g;
    line_on = 1'b1;
    for (n = 0; n < 90; n++) begin
      @(negedge ref_clk);
      dout_ready = !(stall && n > 15 && n < 40);
      if (dout_valid && dout_ready) q.push_back(dout);
      if (n == 60) line_on = 1'b0;
    end
    `CHK("words", 1'b1, q.size() > 0)
    for (n = 0; n < q.size(); n++) `CHK("dout", n % 2 ? e1 : e0, q[n])
  endtask
  // ==========
  // scenarios
  task automatic t_regs;
    `CHK("mode reset", 8'h00, line_pattern_mode_control_q)
    wr(3'h7, 8'ha5, 2'h0);
    wr(3'h3, 8'h00, 2'h0);
    `CHK("mode reg", 8'ha5, line_pattern_mode_control_q)
    wr(3'h7, 8'h00, 2'h0);
  endtask
  task automatic t_tri;
    op_mode = pixel_seq_pkg::MODE_TRI_SHA;
    run_line(12'h123, 10'h000, 12'h000, 12'h123, 12'h123, 1'b0);
    run_line(12'h010, 10'h3ff, 12'h000, 12'h000, 12'h000, 1'b0);
    run_line(12'h800, 10'h000, 12'h800, 12'hc00, 12'hc00, 1'b0);
    run_line(12'hfff, 10'h000, 12'hfff, 12'hfff, 12'hfff, 1'b0);
    op_mode = pixel_seq_pkg::MODE_TRI_CDS;
    run_line(12'h321, 10'h001, 12'h000, 12'h320, 12'h320, 1'b0);
    `CHK("clamp cds", 1'b1, clamp_allowed)
  endtask
  task automatic t_mono;
    op_mode = pixel_seq_pkg::MODE_MONO_SHA;
    config_reg = 8'h40;
    slow = 1'b1;
    wr(3'h1, 8'h04, 2'h2);
    wr(3'h1, 8'hfd, 2'h1);
    wr(3'h2, 8'h08, 2'h2);
    run_line(12'h100, 10'h000, 12'h000, 12'h104, 12'h0fd, 1'b0);
    `CHK("clamp sha", 1'b0, clamp_allowed)
    slow = 1'b0;
  endtask
  task automatic t_area;
    op_mode = pixel_seq_pkg::MODE_TRI_SHA;
    wr(3'h7, 8'h01, 2'h0);
    run_line(12'h200, 10'h000, 12'h000, 12'h204, 12'h208, 1'b0);
    // without the rewrite this line would start on blue
    wr(3'h7, 8'h01, 2'h0);
    run_line(12'h200, 10'h000, 12'h000, 12'h204, 12'h208, 1'b1);
    wr(3'h2, 8'h0c, 2'h2);
    run_line(12'h200, 10'h000, 12'h000, 12'h20c, 12'h204, 1'b0);
  endtask
  // ==========
  // clock, reset, sequence
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #16000;
    fail_count++;
    print_verdict();
  end
  initial begin
    {sys_rst, reg_wr, odd_ofs_wr, even_ofs_wr, line_on, slow, dout_ready} = 7'h41;
    op_mode = pixel_seq_pkg::MODE_TRI_SHA;
    {config_reg, reg_wdata, color_ptr, reg_addr} = 21'h0;
    {level, gain_bus, offset_bus} = 34'h0;
    fail_count = 0;
    checks = 0;
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_regs();
    t_tri();
    t_mono();
    t_area();
    print_verdict();
  end
endmodule
`default_nettype wire
